//--- rtl/rhp_pkg.sv
/*
 * Package for the root hub port status and control block: register offsets,
 * bit positions, reset value and timing constants.
 * Assumes a 100 MHz core_clk and a byte-addressed register access port.
 */
package rhp_pkg;
   localparam int RHP_MAX_PORTS = 4;
   localparam logic [7:0] RHP_PORT0_OFFSET = 8'h54;
   localparam logic [31:0] RHP_RESET_VALUE = 32'h0000_0000;
   // Lower half: state bits
   localparam int RHP_CONN_BIT = 0;
   localparam int RHP_EN_BIT = 1;
   localparam int RHP_SUSP_BIT = 2;
   localparam int RHP_OVC_BIT = 3;
   localparam int RHP_PORTRST_BIT = 4;
   localparam int RHP_PWR_BIT = 8;
   localparam int RHP_LOWSPD_BIT = 9;
   // Upper half: change flags
   localparam int RHP_CONN_CHG_BIT = 16;
   localparam int RHP_EN_CHG_BIT = 17;
   localparam int RHP_SUSP_CHG_BIT = 18;
   localparam int RHP_OVC_CHG_BIT = 19;
   localparam int RHP_RST_CHG_BIT = 20;
   // Writable positions; all others are reserved and read zero
   localparam logic [31:0] RHP_LIVE_MASK = 32'h001F_031F;
   // Timing
   localparam int RHP_CLK_MHZ = 100;
   localparam int RHP_RESET_MS = 10;
   localparam int RHP_RESUME_MS = 20;
   localparam int RHP_RESYNC_MS = 3;
   localparam int RHP_RESET_CYC = RHP_RESET_MS * 1000 * RHP_CLK_MHZ;
   localparam int RHP_RESUME_CYC = RHP_RESUME_MS * 1000 * RHP_CLK_MHZ;
   localparam int RHP_RESYNC_CYC = RHP_RESYNC_MS * 1000 * RHP_CLK_MHZ;
   localparam int RHP_CNT_W = 22;
   localparam int RHP_PHASE_W = 2;
   typedef enum logic [1:0] {RHP_CMD_NONE, RHP_CMD_RESET, RHP_CMD_RESUME} rhp_cmd_e;
endpackage

//--- rtl/rhp_timer.sv
/*
 * One-shot cycle timer for a port: loads a count, pulses done when it expires.
 * Assumes the loading logic shares core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module rhp_timer
   import rhp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [RHP_CNT_W-1:0] load_val,
   output logic busy,
   output logic done
);
   typedef struct packed {
      logic [RHP_CNT_W-1:0] cnt;
      logic busy;
      logic done;
   } rhp_tmr_s;
   rhp_tmr_s st, next_st;

   // Count down; done pulses one cycle at expiry
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (load) begin
         next_st.cnt = load_val;
         next_st.busy = 1'b1;
      end else if (st.busy) begin
         if (st.cnt <= RHP_CNT_W'(1)) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end else begin
            next_st.cnt = st.cnt - RHP_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy = st.busy;
   assign done = st.done;
endmodule // rhp_timer
`default_nettype wire

//--- rtl/rhp_port_status.sv
/*
 * Root hub per-port status and control registers, up to four ports.
 * Assumes the register access port is on core_clk; port pins (connect,
 * low speed, overcurrent, transaction busy, end-of-packet done) are async.
 */
//
// Function
// - One port register per downstream port, count set by downstream_port_count, at most four.
// - State bits sit in the low 16 bits, change flags in the high 16 bits.
// - A state-changing write made during a token-to-handshake transaction waits for its end.
// - Bit 20 sets when the 10 ms port reset ends; writing 1 clears it, 0 does nothing.
// - Bit 19 sets whenever the overcurrent indicator changes; writing 1 clears it.
// - Bit 18 sets after 20 ms resume, low-speed end-of-packet and 3 ms resync; write 1 clears.
// - Bit 18 is cleared by hardware whenever bit 20 becomes set.
// - Every bit of every port register is zero after reset.
// - Bit 16 sets on attach or detach, and on enable, reset or suspend while disconnected.
// - Bit 17 sets only when hardware clears the enable state; writing 1 clears it.
`timescale 1ns/10ps
`default_nettype none
module rhp_port_status
   import rhp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] downstream_port_count,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic [RHP_MAX_PORTS-1:0] pin_connect,
   input wire logic [RHP_MAX_PORTS-1:0] pin_low_speed,
   input wire logic [RHP_MAX_PORTS-1:0] pin_overcurrent,
   input wire logic [RHP_MAX_PORTS-1:0] pin_xact_busy,
   input wire logic [RHP_MAX_PORTS-1:0] pin_ls_eop_done,
   output logic [RHP_MAX_PORTS-1:0] port_reset_drive,
   output logic [RHP_MAX_PORTS-1:0] port_resume_drive,
   output logic [RHP_MAX_PORTS-1:0] port_power_on
);
   localparam int NP = RHP_MAX_PORTS;
   localparam int NS = 5;

   typedef enum logic [1:0] {PH_IDLE, PH_RESUME, PH_EOP, PH_RESYNC} rhp_phase_e;

   typedef struct packed {
      logic [NS-1:0][NP-1:0] s1;
      logic [NS-1:0][NP-1:0] s2;
      logic [NS-1:0][NP-1:0] s3;
      logic [NP-1:0][31:0] regs;
      logic [NP-1:0] pend;
      logic [NP-1:0][31:0] pend_data;
      rhp_phase_e [NP-1:0] phase;
      logic [31:0] rdata;
      logic [NP-1:0] rst_drv;
      logic [NP-1:0] res_drv;
      logic [NP-1:0] pwr;
   } rhp_state_s;
   rhp_state_s st, next_st;

   logic [NP-1:0] tmr_load, tmr_done;
   logic [NP-1:0][RHP_CNT_W-1:0] tmr_val;

   // Decode a word address to a port index; returns NP when unmapped
   function automatic int port_of(input logic [7:0] addr, input logic [2:0] cnt);
      int idx;
      idx = NP;
      for (int p = 0; p < NP; p++) begin
         if (addr == 8'(RHP_PORT0_OFFSET + 8'(4 * p)) && p < int'(cnt)) begin
            idx = p;
         end
      end
      return idx;
   endfunction

   // Debounced level for a pin: second and third stages agree
   function automatic logic agreed(input logic a, input logic b, input logic prev);
      return (a == b) ? a : prev;
   endfunction

   // Per-port timers for reset and resume phases
   for (genvar g = 0; g < NP; g++) begin : g_tmr
      rhp_timer u_tmr (
         .core_clk(core_clk),
         .rst(rst),
         .load(tmr_load[g]),
         .load_val(tmr_val[g]),
         .busy(),
         .done(tmr_done[g])
      );
   end

   // Next state of every port: sync stages, events, writes, timed sequences
   always_comb begin
      logic [NS-1:0][NP-1:0] in;
      logic conn, ls, oc, busy, eop;
      logic [31:0] w;
      logic apply;
      int wp;
      in = {pin_ls_eop_done, pin_xact_busy, pin_overcurrent, pin_low_speed, pin_connect};
      conn = 1'b0;
      ls = 1'b0;
      oc = 1'b0;
      busy = 1'b0;
      eop = 1'b0;
      w = '0;
      apply = 1'b0;
      wp = port_of(reg_addr, downstream_port_count);
      next_st = st;
      tmr_load = '0;
      tmr_val = '0;
      // Three-stage synchronisers; only stages two and three are compared
      next_st.s1 = in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int p = 0; p < NP; p++) begin
         conn = agreed(st.s2[0][p], st.s3[0][p], st.regs[p][RHP_CONN_BIT]);
         ls = agreed(st.s2[1][p], st.s3[1][p], st.regs[p][RHP_LOWSPD_BIT]);
         oc = agreed(st.s2[2][p], st.s3[2][p], st.regs[p][RHP_OVC_BIT]);
         busy = st.s2[3][p] & st.s3[3][p];
         eop = st.s2[4][p] & st.s3[4][p];
         // Software write: clears go first so that hardware sets below win
         apply = 1'b0;
         w = '0;
         if (reg_wr && wp == p) begin
            w = reg_wdata & RHP_LIVE_MASK;
            for (int b = RHP_CONN_CHG_BIT; b <= RHP_RST_CHG_BIT; b++) begin
               if (w[b]) begin
                  next_st.regs[p][b] = 1'b0;
               end
            end
            if (busy) begin
               next_st.pend[p] = 1'b1;
               next_st.pend_data[p] = w;
            end else begin
               apply = 1'b1;
            end
         end else if (st.pend[p] && !busy) begin
            apply = 1'b1;
            w = st.pend_data[p];
            next_st.pend[p] = 1'b0;
         end
         // Hardware status and events
         if (conn != st.regs[p][RHP_CONN_BIT]) begin
            next_st.regs[p][RHP_CONN_CHG_BIT] = 1'b1;
            if (!conn && st.regs[p][RHP_EN_BIT]) begin
               next_st.regs[p][RHP_EN_BIT] = 1'b0;
               next_st.regs[p][RHP_EN_CHG_BIT] = 1'b1;
            end
         end
         next_st.regs[p][RHP_CONN_BIT] = conn;
         next_st.regs[p][RHP_LOWSPD_BIT] = conn & ls;
         if (oc != st.regs[p][RHP_OVC_BIT]) begin
            next_st.regs[p][RHP_OVC_CHG_BIT] = 1'b1;
            if (oc && st.regs[p][RHP_EN_BIT]) begin
               next_st.regs[p][RHP_EN_BIT] = 1'b0;
               next_st.regs[p][RHP_EN_CHG_BIT] = 1'b1;
            end
         end
         next_st.regs[p][RHP_OVC_BIT] = oc;
         // State-changing part of the write, now or after the deferral
         if (apply) begin
            next_st.pend[p] = 1'b0;
            if (!conn && (w[RHP_EN_BIT] | w[RHP_SUSP_BIT] | w[RHP_PORTRST_BIT])) begin
               next_st.regs[p][RHP_CONN_CHG_BIT] = 1'b1;
            end else begin
               if (w[RHP_EN_BIT]) begin
                  next_st.regs[p][RHP_EN_BIT] = 1'b1;
               end
               if (w[RHP_SUSP_BIT] && st.regs[p][RHP_EN_BIT]) begin
                  next_st.regs[p][RHP_SUSP_BIT] = 1'b1;
               end
               if (w[RHP_PORTRST_BIT]) begin
                  next_st.regs[p][RHP_PORTRST_BIT] = 1'b1;
                  next_st.phase[p] = PH_IDLE;
                  tmr_load[p] = 1'b1;
                  tmr_val[p] = RHP_CNT_W'(RHP_RESET_CYC);
               end
            end
            // Bit 0 written as 1 clears enable; bit 3 clears suspend (resume)
            if (w[RHP_CONN_BIT]) begin
               next_st.regs[p][RHP_EN_BIT] = 1'b0;
            end
            if (w[RHP_OVC_BIT] && st.regs[p][RHP_SUSP_BIT] && st.phase[p] == PH_IDLE) begin
               next_st.phase[p] = PH_RESUME;
               tmr_load[p] = 1'b1;
               tmr_val[p] = RHP_CNT_W'(RHP_RESUME_CYC);
            end
            if (w[RHP_PWR_BIT]) begin
               next_st.regs[p][RHP_PWR_BIT] = 1'b1;
            end
            if (w[RHP_LOWSPD_BIT]) begin
               next_st.regs[p][RHP_PWR_BIT] = 1'b0;
            end
         end
         // Timed sequences
         if (tmr_done[p] && st.regs[p][RHP_PORTRST_BIT]) begin
            next_st.regs[p][RHP_PORTRST_BIT] = 1'b0;
            next_st.regs[p][RHP_EN_BIT] = 1'b1;
            next_st.regs[p][RHP_RST_CHG_BIT] = 1'b1;
         end
         case (st.phase[p])
            PH_IDLE: begin
            end
            PH_RESUME: begin
               if (tmr_done[p]) begin
                  next_st.phase[p] = PH_EOP;
               end
            end
            PH_EOP: begin
               if (eop) begin
                  next_st.phase[p] = PH_RESYNC;
                  tmr_load[p] = 1'b1;
                  tmr_val[p] = RHP_CNT_W'(RHP_RESYNC_CYC);
               end
            end
            PH_RESYNC: begin
               if (tmr_done[p]) begin
                  next_st.phase[p] = PH_IDLE;
                  next_st.regs[p][RHP_SUSP_BIT] = 1'b0;
                  next_st.regs[p][RHP_SUSP_CHG_BIT] = 1'b1;
               end
            end
            default: begin
               next_st.phase[p] = PH_IDLE;
            end
         endcase
         // Completed reset wins over suspend change
         if (next_st.regs[p][RHP_RST_CHG_BIT] && !st.regs[p][RHP_RST_CHG_BIT]) begin
            next_st.regs[p][RHP_SUSP_CHG_BIT] = 1'b0;
         end
         next_st.regs[p] = next_st.regs[p] & RHP_LIVE_MASK;
         next_st.rst_drv[p] = next_st.regs[p][RHP_PORTRST_BIT];
         next_st.res_drv[p] = (next_st.phase[p] == PH_RESUME);
         next_st.pwr[p] = next_st.regs[p][RHP_PWR_BIT];
      end
      // Registered read; unmapped words read zero
      next_st.rdata = '0;
      if (reg_rd && wp < NP) begin
         next_st.rdata = st.regs[wp[1:0]];
      end
   end

   // Single state register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign port_reset_drive = st.rst_drv;
   assign port_resume_drive = st.res_drv;
   assign port_power_on = st.pwr;
endmodule // rhp_port_status
`default_nettype wire

//--- sim/rhp_monitor.sv
/* Checker for the root hub port registers.
   Bound to rhp_port_status; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module rhp_monitor
   import rhp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] downstream_port_count,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_rdata,
   input wire logic [RHP_MAX_PORTS-1:0] port_reset_drive,
   input wire logic [RHP_MAX_PORTS-1:0] port_resume_drive
);
   logic [7:0] off;
   logic in_win;
   // Word slot inside the four-port window
   assign off = reg_addr - RHP_PORT0_OFFSET;
   assign in_win = reg_addr >= RHP_PORT0_OFFSET && off[1:0] == 2'h0 && off[7:2] < 6'h4;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data not zero when idle");
   a_resv_high: assert property (reg_rdata[31:21] == '0)
      else $error("upper reserved bits set");
   a_resv_low: assert property (reg_rdata[15:10] == '0 && reg_rdata[7:5] == '0)
      else $error("lower reserved bits set");
   a_reset_zero: assert property ($past(rst) |->
      reg_rdata == '0 && port_reset_drive == '0 && port_resume_drive == '0)
      else $error("outputs not zero after reset");
   a_unmapped_zero: assert property (reg_rd && !in_win |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   a_over_count: assert property (reg_rd && in_win &&
      off[7:2] >= {3'h0, downstream_port_count} |=> reg_rdata == '0)
      else $error("read beyond port count not zero");
   a_reset_hold: assert property ($rose(|port_reset_drive) |-> (|port_reset_drive)[*8])
      else $error("port reset pulse too short");
   a_resume_hold: assert property ($rose(|port_resume_drive) |-> (|port_resume_drive)[*8])
      else $error("resume pulse too short");
endmodule // rhp_monitor
bind rhp_port_status rhp_monitor u_mon (.core_clk, .rst, .downstream_port_count, .reg_rd,
   .reg_addr, .reg_rdata, .port_reset_drive, .port_resume_drive);
`default_nettype wire

//--- sim/rhp_dev_model.sv
/* Devices on the four downstream ports.
   Bench sets attach, speed, fault and traffic levels per port. */
`timescale 1ns/10ps
`default_nettype none
module rhp_dev_model
   import rhp_pkg::*;
(
   input wire logic core_clk,
   input wire logic [3:0] attach,
   input wire logic [3:0] slow,
   input wire logic [3:0] fault,
   input wire logic [3:0] busy,
   input wire logic [3:0] port_resume_drive,
   output logic [3:0] pin_connect,
   output logic [3:0] pin_low_speed,
   output logic [3:0] pin_overcurrent,
   output logic [3:0] pin_xact_busy,
   output logic [3:0] pin_ls_eop_done
);
   logic [3:0] resume_q;
   // Detached lines sit at the host pull-down, so no stale speed shows
   always_comb begin
      pin_connect = attach;
      pin_low_speed = attach & slow;
      pin_overcurrent = fault;
      pin_xact_busy = busy & attach;
   end
   // End-of-packet reported one cycle after the resume pulse ends
   always @(posedge core_clk) begin
      resume_q <= port_resume_drive;
      pin_ls_eop_done <= resume_q & ~port_resume_drive;
   end
endmodule // rhp_dev_model
`default_nettype wire

//--- sim/tb.sv
/* Self-checking bench for the root hub port registers.
   Drives the register port and the device model on core_clk. */
`timescale 1ns/10ps
`default_nettype none
module tb import rhp_pkg::*;;
   logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
   logic [2:0] cnt = 3'h4;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, got, ls;
   logic [3:0] attach = '0, slow = '0, fault = '0, busy = '0;
   logic [3:0] pc, pls, poc, pxb, peop, rdrv, sdrv, pwr;
   logic [15:0] lfsr = 16'h65F3;
   int err_total = 0, num_checks = 0, p, q, r, u;
   // Free-running 100 MHz clock
   initial forever #5 core_clk = ~core_clk;
   rhp_port_status dut (.core_clk(core_clk), .rst(rst), .downstream_port_count(cnt),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .pin_connect(pc), .pin_low_speed(pls), .pin_overcurrent(poc),
      .pin_xact_busy(pxb), .pin_ls_eop_done(peop), .port_reset_drive(rdrv),
      .port_resume_drive(sdrv), .port_power_on(pwr));
   rhp_dev_model dev (.core_clk(core_clk), .attach(attach), .slow(slow), .fault(fault),
      .busy(busy), .port_resume_drive(sdrv), .pin_connect(pc), .pin_low_speed(pls),
      .pin_overcurrent(poc), .pin_xact_busy(pxb), .pin_ls_eop_done(peop));
   function automatic logic [15:0] next_rand(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Strobes rise 1 ns after an edge and stay one cycle
   task automatic wr(int port, logic [31:0] d);
      @(posedge core_clk);
      #1;
      reg_wr = 1;
      reg_addr = RHP_PORT0_OFFSET + 8'(4 * port);
      reg_wdata = d;
      idle(1);
      reg_wr = 0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge core_clk);
      #1;
      reg_rd = 1;
      reg_addr = a;
      idle(1);
      reg_rd = 0;
      got = reg_rdata;
   endtask
   task automatic rp(int port, logic [31:0] exp);
      rd(RHP_PORT0_OFFSET + 8'(4 * port));
      check("port reg", got, exp);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      final_report();
   end
   // Main sequence
   initial begin
      idle(3);
      rst = 0;
      for (int i = 0; i < 4; i++) rp(i, '0);
      lfsr = next_rand(lfsr);
      p = lfsr[1:0];
      q = p ^ 1;
      r = p ^ 2;
      u = p ^ 3;
      ls = {22'h0, lfsr[2], 9'h0};
      wr(p, 32'h0000_0100);
      slow[p] = lfsr[2];
      attach[p] = 1;
      idle(8);
      rp(p, 32'h0001_0101 | ls);
      check("power", 32'(pwr[p]), 32'h0000_0001);
      wr(p, '0);
      rp(p, 32'h0001_0101 | ls);
      wr(p, 32'h0001_0000);
      rp(p, 32'h0000_0101 | ls);
      $display("attach test done");
      busy[p] = 1;
      idle(6);
      wr(p, 32'h0000_0002);
      idle(2);
      rp(p, 32'h0000_0101 | ls);
      busy[p] = 0;
      idle(8);
      rp(p, 32'h0000_0103 | ls);
      wr(p, 32'h0000_0001);
      rp(p, 32'h0000_0101 | ls);
      $display("deferral test done");
      wr(p, 32'h0000_0002);
      fault[p] = 1;
      idle(8);
      rp(p, 32'h000A_0109 | ls);
      fault[p] = 0;
      idle(8);
      rp(p, 32'h000A_0101 | ls);
      wr(p, 32'h000F_0000);
      rp(p, 32'h0000_0101 | ls);
      wr(p, 32'h0000_0002);
      wr(p, 32'h0000_0004);
      rp(p, 32'h0000_0107 | ls);
      wr(p, 32'h0000_0008);
      idle(3);
      check("resume drive", 32'(sdrv[p]), 32'h0000_0001);
      rd(RHP_PORT0_OFFSET + 8'(4 * p));
      check("suspend change", 32'(got[18]), '0);
      $display("overcurrent and resume test done");
      wr(q, 32'h0000_0100);
      attach[q] = 1;
      idle(8);
      wr(q, 32'h0000_0002);
      rp(q, 32'h0001_0103);
      attach[q] = 0;
      idle(8);
      rp(q, 32'h0003_0100);
      wr(q, 32'h0003_0000);
      wr(q, 32'h0000_0010);
      rp(q, 32'h0001_0100);
      wr(q, 32'h0000_0200);
      rp(q, 32'h0001_0000);
      check("power off", 32'(pwr[q]), '0);
      // Clear lands on the very edge the synced attach is seen: set must win
      attach[u] = 1;
      idle(2);
      wr(u, 32'h0001_0000);
      rp(u, 32'h0001_0001);
      wr(r, 32'h0000_0100);
      attach[r] = 1;
      idle(8);
      wr(r, 32'h0001_0010);
      rp(r, 32'h0000_0111);
      check("reset drive", 32'(rdrv[r]), 32'h0000_0001);
      $display("detach and reset test done");
      cnt = 3'h2;
      rp(3, '0);
      rd(8'h40);
      check("unmapped", got, '0);
      rd(8'h55);
      check("unaligned", got, '0);
      cnt = 3'h4;
      attach = '0;
      idle(8);
      rst = 1;
      idle(3);
      rst = 0;
      for (int i = 0; i < 4; i++) rp(i, '0);
      check("drives", {20'h0, pwr, rdrv, sdrv}, '0);
      $display("map and reset test done");
      final_report();
   end
endmodule // tb
`default_nettype wire
